// ### rtl/crs_pkg.sv
// Constants, commands and carrier types of the core register state block
package crs_pkg;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] SP_RESET = 8'h07;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] B_RESET = 8'h00;
   localparam logic [7:0] PSW_RESET = 8'h00;
   localparam logic [15:0] EXTERNAL_DATA_POINTER_RESET = 16'h0000;
   localparam logic [7:0] PAGE_RESET = 8'h00;

   // ---------------------------------------------------------------
   // Memory map
   // ---------------------------------------------------------------
   localparam int RAM_BYTES = 256;
   localparam logic [7:0] BIT_AREA_BASE = 8'h20;
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam logic [7:0] SFR_SP = 8'h81;
   localparam logic [7:0] SFR_DPL = 8'h82;
   localparam logic [7:0] SFR_DPH = 8'h83;
   localparam logic [7:0] SFR_PAGE = 8'h84;
   localparam logic [7:0] SFR_PSW = 8'hD0;
   localparam logic [7:0] SFR_ACC = 8'hE0;
   localparam logic [7:0] SFR_B = 8'hF0;

   // ---------------------------------------------------------------
   // Flag word bit positions
   // ---------------------------------------------------------------
   localparam int CY_BIT = 7;
   localparam int AC_BIT = 6;
   localparam int F0_BIT = 5;
   localparam int RS1_BIT = 4;
   localparam int RS0_BIT = 3;
   localparam int OV_BIT = 2;
   localparam int P_BIT = 0;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NONE, OP_DIR_RD, OP_DIR_WR, OP_IND_RD, OP_IND_WR, OP_BIT_RD,
      OP_BIT_WR, OP_REG_RD, OP_REG_WR, OP_PUSH, OP_POP, OP_CALL, OP_INT,
      OP_PC_STEP, OP_PC_LOAD, OP_ADD, OP_ADDC, OP_SUBB, OP_RLC, OP_RRC,
      OP_MUL, OP_DIV, OP_EXTERNAL_DATA_POINTER_INC, OP_EXTERNAL_DATA_POINTER_LOAD, OP_CODE_WR
   } crs_op_t;

   typedef enum logic [1:0] {PH_IDLE, PH_CALL_LO, PH_CALL_HI} crs_phase_t;

   typedef struct packed {
      crs_op_t op;
      logic [7:0] addr;
      logic [7:0] data;
      logic [15:0] target;
   } crs_cmd_t;

   typedef struct packed {
      logic [7:0] rdData;
      logic done;
   } crs_resp_t;

   typedef struct packed {
      logic wr;
      logic [15:0] addr;
      logic [7:0] data;
   } crs_code_t;

   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] b;
      logic [7:0] sp;
      logic [7:0] cpu_flag_word;
      logic [15:0] pc;
      logic [15:0] external_data_pointer;
      logic [23:0] extAddr;
   } crs_view_t;

   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] b;
      logic [7:0] sp;
      logic [7:0] cpu_flag_word;
      logic [15:0] pc;
      logic [15:0] external_data_pointer;
      logic [7:0] page;
      logic [15:0] callTarget;
      crs_phase_t phase;
      logic [7:0] rdData;
      logic done;
      crs_code_t code;
      logic progMeta;
      logic progSync;
   } crs_state_t;

endpackage : crs_pkg

// ### rtl/crs_core_regs.sv
// Architectural register state and internal data memory of the core
`timescale 1ns/100ps
module crs_core_regs
   import crs_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Command from the execution unit
   input wire crs_cmd_t cmd,
   output logic busy,
   // Flash programming enable pin
   input wire logic progEnable,
   // Results
   output crs_resp_t resp,
   output crs_code_t code,
   // Register view
   output crs_view_t view
);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   crs_state_t st_reg;
   crs_state_t st_next;
   logic [7:0] ram [0:RAM_BYTES-1];
   logic ramWe;
   logic [7:0] ramAddr;
   logic [7:0] ramWData;

   // ---------------------------------------------------------------
   // Arithmetic helpers
   // ---------------------------------------------------------------
   logic cin;
   logic [8:0] addSum;
   logic [4:0] addLow;
   logic [8:0] subDiff;
   logic [4:0] subLow;
   logic [15:0] prod;
   logic [7:0] divisor;
   logic parity;
   logic [7:0] bitByte;
   logic [7:0] bitVal;
   logic [7:0] bitNew;
   logic [7:0] regAddr;

   assign cin = (cmd.op == OP_ADD) ? 1'b0 : st_reg.cpu_flag_word[CY_BIT];
   assign addSum = {1'b0, st_reg.acc} + {1'b0, cmd.data} + {8'h00, cin};
   assign addLow = {1'b0, st_reg.acc[3:0]} + {1'b0, cmd.data[3:0]}
      + {4'h0, cin};
   assign subDiff = {1'b0, st_reg.acc} - {1'b0, cmd.data} - {8'h00, cin};
   assign subLow = {1'b0, st_reg.acc[3:0]} - {1'b0, cmd.data[3:0]}
      - {4'h0, cin};
   assign prod = {8'h00, st_reg.acc} * {8'h00, st_reg.b};
   assign divisor = (st_reg.b == 8'h00) ? 8'h01 : st_reg.b;
   assign parity = ^st_reg.acc;

   // Working register inside the bank chosen by the flag word
   assign regAddr = {3'b000, st_reg.cpu_flag_word[RS1_BIT], st_reg.cpu_flag_word[RS0_BIT],
      cmd.addr[2:0]};

   // Bit address: low half maps to RAM 20h..2Fh, high half to
   // special registers whose address ends in 0h or 8h
   assign bitByte = cmd.addr[7] ? {cmd.addr[7:3], 3'b000}
      : BIT_AREA_BASE + {4'h0, cmd.addr[6:3]};

   // ---------------------------------------------------------------
   // Special register access
   // ---------------------------------------------------------------
   function automatic logic [7:0] sfrRead(input logic [7:0] a,
      input crs_state_t s, input logic par);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         SFR_ACC: v = s.acc;
         SFR_B: v = s.b;
         SFR_SP: v = s.sp;
         SFR_PSW: v = {s.cpu_flag_word[7:1], par};
         SFR_DPL: v = s.external_data_pointer[7:0];
         SFR_DPH: v = s.external_data_pointer[15:8];
         SFR_PAGE: v = s.page;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : sfrRead

   function automatic crs_state_t sfrWrite(input crs_state_t s,
      input logic [7:0] a, input logic [7:0] d);
      crs_state_t r;
      r = s;
      case (a)
         SFR_ACC: r.acc = d;
         SFR_B: r.b = d;
         SFR_SP: r.sp = d;
         SFR_PSW: r.cpu_flag_word = {d[7:1], 1'b0};
         SFR_DPL: r.external_data_pointer[7:0] = d;
         SFR_DPH: r.external_data_pointer[15:8] = d;
         SFR_PAGE: r.page = d;
         default: r = s;
      endcase
      return r;
   endfunction : sfrWrite

   assign bitVal = cmd.addr[7] ? sfrRead(bitByte, st_reg, parity)
      : ram[bitByte];

   always_comb begin
      bitNew = bitVal;
      bitNew[cmd.addr[2:0]] = cmd.data[0];
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      st_next.code.wr = 1'b0;
      st_next.progMeta = progEnable;
      st_next.progSync = st_reg.progMeta;
      ramWe = 1'b0;
      ramAddr = 8'h00;
      ramWData = 8'h00;
      case (st_reg.phase)
         PH_CALL_LO: begin
            st_next.sp = st_reg.sp + 8'h01;
            ramWe = 1'b1;
            ramAddr = st_reg.sp + 8'h01;
            ramWData = st_reg.pc[7:0];
            st_next.phase = PH_CALL_HI;
         end
         PH_CALL_HI: begin
            st_next.sp = st_reg.sp + 8'h01;
            ramWe = 1'b1;
            ramAddr = st_reg.sp + 8'h01;
            ramWData = st_reg.pc[15:8];
            st_next.pc = st_reg.callTarget;
            st_next.phase = PH_IDLE;
            st_next.done = 1'b1;
         end
         PH_IDLE: begin
            st_next.done = (cmd.op != OP_NONE) && (cmd.op != OP_CALL)
               && (cmd.op != OP_INT);
            case (cmd.op)
               OP_DIR_RD: begin
                  if (cmd.addr[7]) begin
                     st_next.rdData = sfrRead(cmd.addr, st_reg, parity);
                  end else begin
                     st_next.rdData = ram[cmd.addr];
                  end
               end
               OP_DIR_WR: begin
                  if (cmd.addr[7]) begin
                     st_next = sfrWrite(st_next, cmd.addr, cmd.data);
                  end else begin
                     ramWe = 1'b1;
                     ramAddr = cmd.addr;
                     ramWData = cmd.data;
                  end
               end
               OP_IND_RD: st_next.rdData = ram[cmd.addr];
               OP_IND_WR: begin
                  ramWe = 1'b1;
                  ramAddr = cmd.addr;
                  ramWData = cmd.data;
               end
               OP_BIT_RD: st_next.rdData = {7'h00, bitVal[cmd.addr[2:0]]};
               OP_BIT_WR: begin
                  if (cmd.addr[7]) begin
                     st_next = sfrWrite(st_next, bitByte, bitNew);
                  end else begin
                     ramWe = 1'b1;
                     ramAddr = bitByte;
                     ramWData = bitNew;
                  end
               end
               OP_REG_RD: st_next.rdData = ram[regAddr];
               OP_REG_WR: begin
                  ramWe = 1'b1;
                  ramAddr = regAddr;
                  ramWData = cmd.data;
               end
               OP_PUSH: begin
                  st_next.sp = st_reg.sp + 8'h01;
                  ramWe = 1'b1;
                  ramAddr = st_reg.sp + 8'h01;
                  ramWData = cmd.data;
               end
               OP_POP: begin
                  st_next.rdData = ram[st_reg.sp];
                  st_next.sp = st_reg.sp - 8'h01;
               end
               OP_CALL: begin
                  st_next.callTarget = cmd.target;
                  st_next.phase = PH_CALL_LO;
               end
               OP_INT: begin
                  st_next.callTarget = VEC_BASE
                     + {8'h00, cmd.addr[4:0], 3'b000};
                  st_next.phase = PH_CALL_LO;
               end
               OP_PC_STEP: st_next.pc = st_reg.pc + 16'h0001;
               OP_PC_LOAD: st_next.pc = cmd.target;
               OP_ADD, OP_ADDC: begin
                  st_next.acc = addSum[7:0];
                  st_next.cpu_flag_word[CY_BIT] = addSum[8];
                  st_next.cpu_flag_word[AC_BIT] = addLow[4];
                  st_next.cpu_flag_word[OV_BIT] = (st_reg.acc[7] == cmd.data[7])
                     && (addSum[7] != st_reg.acc[7]);
               end
               OP_SUBB: begin
                  st_next.acc = subDiff[7:0];
                  st_next.cpu_flag_word[CY_BIT] = ~subDiff[8];
                  st_next.cpu_flag_word[AC_BIT] = ~subLow[4];
                  st_next.cpu_flag_word[OV_BIT] = (st_reg.acc[7] != cmd.data[7])
                     && (subDiff[7] != st_reg.acc[7]);
               end
               OP_RLC: begin
                  st_next.acc = {st_reg.acc[6:0], st_reg.cpu_flag_word[CY_BIT]};
                  st_next.cpu_flag_word[CY_BIT] = st_reg.acc[7];
               end
               OP_RRC: begin
                  st_next.acc = {st_reg.cpu_flag_word[CY_BIT], st_reg.acc[7:1]};
                  st_next.cpu_flag_word[CY_BIT] = st_reg.acc[0];
               end
               OP_MUL: begin
                  st_next.acc = prod[7:0];
                  st_next.b = prod[15:8];
                  st_next.cpu_flag_word[CY_BIT] = 1'b0;
                  st_next.cpu_flag_word[OV_BIT] = (prod[15:8] != 8'h00);
               end
               OP_DIV: begin
                  st_next.cpu_flag_word[CY_BIT] = 1'b0;
                  st_next.cpu_flag_word[OV_BIT] = (st_reg.b == 8'h00);
                  if (st_reg.b != 8'h00) begin
                     st_next.acc = st_reg.acc / divisor;
                     st_next.b = st_reg.acc % divisor;
                  end
               end
               OP_EXTERNAL_DATA_POINTER_INC: st_next.external_data_pointer = st_reg.external_data_pointer + 16'h0001;
               OP_EXTERNAL_DATA_POINTER_LOAD: st_next.external_data_pointer = cmd.target;
               OP_CODE_WR: begin
                  if (st_reg.progSync) begin
                     st_next.code.wr = 1'b1;
                     st_next.code.addr = cmd.target;
                     st_next.code.data = cmd.data;
                  end
               end
               default: st_next.done = 1'b0;
            endcase
         end
         default: st_next.phase = PH_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
         st_reg.acc <= ACC_RESET;
         st_reg.b <= B_RESET;
         st_reg.sp <= SP_RESET;
         st_reg.cpu_flag_word <= PSW_RESET;
         st_reg.pc <= PC_RESET;
         st_reg.external_data_pointer <= EXTERNAL_DATA_POINTER_RESET;
         st_reg.page <= PAGE_RESET;
         st_reg.phase <= PH_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // Internal RAM, contents undefined after reset
   always_ff @(posedge mclk) begin
      if (ramWe) begin
         ram[ramAddr] <= ramWData;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign busy = (st_reg.phase != PH_IDLE);
   assign resp = '{rdData: st_reg.rdData, done: st_reg.done};
   assign code = st_reg.code;
   // Program space is fetched by pc, data space by external_data_pointer and page
   assign view = '{acc: st_reg.acc, b: st_reg.b, sp: st_reg.sp,
      cpu_flag_word: {st_reg.cpu_flag_word[7:1], parity}, pc: st_reg.pc, external_data_pointer: st_reg.external_data_pointer,
      extAddr: {st_reg.page, st_reg.external_data_pointer}};

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic firstCycle;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         firstCycle <= 1'b1;
      end else begin
         firstCycle <= 1'b0;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence callTaken;
      !busy && (cmd.op == OP_INT);
   endsequence

   sequence callDone;
      ##1 busy ##1 busy ##1 (resp.done && !busy);
   endsequence

   a_sp_push_incr: assert property (
      (!busy && cmd.op == OP_PUSH) |=> (view.sp == $past(view.sp) + 8'h01)
         && (ram[view.sp] == $past(cmd.data)))
      else $error("push did not pre-increment stack index");

   a_reset_values: assert property (
      firstCycle |-> (view.sp == 8'h07))
      else $error("stack index not 07h after reset");

   a_pc_reset: assert property (
      firstCycle |-> (view.pc == 16'h0000))
      else $error("program counter not zero after reset");

   a_pc_step: assert property (
      (!busy && cmd.op == OP_PC_STEP) |=> view.pc == $past(view.pc) + 16'h1)
      else $error("program counter did not advance");

   a_int_vector: assert property (
      callTaken ##0 callDone |-> view.pc[2:0] == 3'b011
         && view.sp == $past(view.sp, 3) + 8'h02)
      else $error("interrupt vector or stacking wrong");

   a_parity_even: assert property (
      ^{view.acc, view.cpu_flag_word[0]} == 1'b0)
      else $error("parity flag polarity wrong");

   a_add_flags: assert property (
      (!busy && cmd.op == OP_ADD && cmd.data == 8'h01
         && view.acc == 8'h7F) |=> view.cpu_flag_word[2] && !view.cpu_flag_word[7])
      else $error("signed range flag not set on 7Fh plus 1");

   a_bank_map: assert property (
      (!busy && cmd.op == OP_REG_WR) |-> ramWe
         && ramAddr[4:3] == view.cpu_flag_word[4:3] && ramAddr[7:5] == 3'b000)
      else $error("working register outside active bank");

   a_code_guard: assert property (
      code.wr |-> $past(st_reg.progSync))
      else $error("code write outside programming");

   a_mul_pair: assert property (
      (!busy && cmd.op == OP_MUL) |=>
         {view.b, view.acc} == $past(view.acc) * $past(view.b))
      else $error("product not placed in operand pair");

endmodule : crs_core_regs

// ### tb/crs_core_regs_tb.sv
// Self-checking bench for the core register state block
`timescale 1ns/100ps
module crs_core_regs_tb import crs_pkg::*;;
   // ---------------------------------------------------------------
   // Signals and instance
   // ---------------------------------------------------------------
   logic mclk;
   logic reset_n;
   logic progEnable;
   logic busy;
   crs_cmd_t cmd;
   crs_resp_t resp;
   crs_code_t code;
   crs_view_t view;
   int num_errors;
   int checks;
   logic [7:0] rdv;
   logic cwr;
   logic [7:0] sp0;

   crs_core_regs i_crs_core_regs (
      .mclk(mclk),
      .reset_n(reset_n),
      .cmd(cmd),
      .busy(busy),
      .progEnable(progEnable),
      .resp(resp),
      .code(code),
      .view(view)
   );

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chkw(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chkw

   // One command, held for the taking edge, then wait for done
   task automatic do_op(input crs_op_t op, input logic [7:0] a,
         input logic [7:0] d, input logic [15:0] t);
      int n;
      cmd = '{op: op, addr: a, data: d, target: t};
      @(posedge mclk);
      #1;
      cmd.op = OP_NONE;
      n = 0;
      while (resp.done !== 1'b1 && n < 8) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (resp.done !== 1'b1) begin
         num_errors++;
         $display("unexpected at %0t: done 0 expected 1", $time);
         end_sim();
      end
      rdv = resp.rdData;
      cwr = code.wr;
      @(posedge mclk);
      #1;
   endtask : do_op

   task automatic alu(input crs_op_t op, input logic [7:0] a,
         input logic [7:0] d, input logic [7:0] r, input logic [7:0] f);
      do_op(OP_DIR_WR, SFR_PSW, 8'h00, 16'h0000);
      do_op(OP_DIR_WR, SFR_ACC, a, 16'h0000);
      do_op(op, 8'h00, d, 16'h0000);
      chk8(view.acc, r);
      chk8(view.cpu_flag_word & 8'hC4, f);
   endtask : alu

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      progEnable = 1'b0;
      cmd = '0;
      num_errors = 0;
      checks = 0;
      repeat (8) @(posedge mclk);
      #1;
      reset_n = 1'b1;
      chk8(view.sp, 8'h07);
      chkw(view.pc, 24'h000000);
      chk8(view.cpu_flag_word, 8'h00);
      $display("test reset done");

      do_op(OP_PUSH, 8'h00, 8'h5A, 16'h0000);
      chk8(view.sp, 8'h08);
      do_op(OP_IND_RD, 8'h08, 8'h00, 16'h0000);
      chk8(rdv, 8'h5A);
      do_op(OP_POP, 8'h00, 8'h00, 16'h0000);
      chk8(rdv, 8'h5A);
      chk8(view.sp, 8'h07);
      do_op(OP_DIR_RD, 8'h08, 8'h00, 16'h0000);
      chk8(rdv, 8'h5A);
      $display("test stack done");

      for (int k = 0; k < 4; k++) begin
         do_op(OP_DIR_WR, SFR_PSW, 8'(k << 3), 16'h0000);
         chk8(view.cpu_flag_word & 8'h18, 8'(k << 3));
         do_op(OP_REG_WR, 8'h07, 8'(8'h40 + k), 16'h0000);
         do_op(OP_IND_RD, 8'(k * 8 + 7), 8'h00, 16'h0000);
         chk8(rdv, 8'(8'h40 + k));
      end
      do_op(OP_REG_RD, 8'h07, 8'h00, 16'h0000);
      chk8(rdv, 8'h43);
      $display("test banks done");

      do_op(OP_DIR_WR, SFR_ACC, 8'h11, 16'h0000);
      do_op(OP_IND_WR, SFR_ACC, 8'hA5, 16'h0000);
      chk8(view.acc, 8'h11);
      do_op(OP_IND_RD, SFR_ACC, 8'h00, 16'h0000);
      chk8(rdv, 8'hA5);
      do_op(OP_DIR_RD, SFR_ACC, 8'h00, 16'h0000);
      chk8(rdv, 8'h11);
      do_op(OP_DIR_RD, SFR_SP, 8'h00, 16'h0000);
      chk8(rdv, 8'h07);
      $display("test direct done");

      do_op(OP_IND_WR, 8'h2F, 8'h00, 16'h0000);
      do_op(OP_IND_WR, 8'h20, 8'h00, 16'h0000);
      do_op(OP_BIT_WR, 8'h7F, 8'h01, 16'h0000);
      do_op(OP_BIT_WR, 8'h00, 8'h01, 16'h0000);
      do_op(OP_IND_RD, 8'h2F, 8'h00, 16'h0000);
      chk8(rdv, 8'h80);
      do_op(OP_IND_RD, 8'h20, 8'h00, 16'h0000);
      chk8(rdv, 8'h01);
      do_op(OP_BIT_RD, 8'h7F, 8'h00, 16'h0000);
      chk8(rdv & 8'h01, 8'h01);
      do_op(OP_DIR_WR, SFR_ACC, 8'h00, 16'h0000);
      do_op(OP_BIT_WR, 8'hE3, 8'h01, 16'h0000);
      chk8(view.acc, 8'h08);
      do_op(OP_DIR_WR, SFR_B, 8'h00, 16'h0000);
      do_op(OP_BIT_WR, 8'hF7, 8'h01, 16'h0000);
      chk8(view.b, 8'h80);
      $display("test bits done");

      for (int k = 0; k < 4; k++) begin
         do_op(OP_PC_LOAD, 8'h00, 8'h00, 16'(16'h1200 + k));
         sp0 = view.sp;
         do_op(OP_INT, 8'(k), 8'h00, 16'h0000);
         chkw(view.pc, 24'(16'h0003 + 8 * k));
         chk8(view.sp, 8'(sp0 + 2));
         do_op(OP_IND_RD, 8'(sp0 + 1), 8'h00, 16'h0000);
         chk8(rdv, 8'(k));
         do_op(OP_IND_RD, 8'(sp0 + 2), 8'h00, 16'h0000);
         chk8(rdv, 8'h12);
      end
      do_op(OP_CALL, 8'h00, 8'h00, 16'h4567);
      chkw(view.pc, 24'h004567);
      do_op(OP_PC_LOAD, 8'h00, 8'h00, 16'hFFFF);
      do_op(OP_PC_STEP, 8'h00, 8'h00, 16'h0000);
      chkw(view.pc, 24'h000000);
      $display("test vectors done");

      alu(OP_ADD, 8'h7F, 8'h01, 8'h80, 8'h44);
      alu(OP_ADD, 8'hFF, 8'h01, 8'h00, 8'hC0);
      alu(OP_SUBB, 8'h80, 8'h01, 8'h7F, 8'h84);
      alu(OP_SUBB, 8'h05, 8'h03, 8'h02, 8'hC0);
      alu(OP_RLC, 8'h81, 8'h00, 8'h02, 8'h80);
      alu(OP_RRC, 8'h01, 8'h00, 8'h00, 8'h80);
      do_op(OP_DIR_WR, SFR_ACC, 8'h10, 16'h0000);
      do_op(OP_ADDC, 8'h00, 8'h01, 16'h0000);
      chk8(view.acc, 8'h12);
      do_op(OP_DIR_WR, SFR_ACC, 8'h07, 16'h0000);
      chk8(view.cpu_flag_word & 8'h01, 8'h01);
      do_op(OP_DIR_WR, SFR_ACC, 8'h03, 16'h0000);
      chk8(view.cpu_flag_word & 8'h01, 8'h00);
      $display("test flags done");

      do_op(OP_DIR_WR, SFR_ACC, 8'h10, 16'h0000);
      do_op(OP_DIR_WR, SFR_B, 8'h20, 16'h0000);
      do_op(OP_MUL, 8'h00, 8'h00, 16'h0000);
      chkw({view.b, view.acc}, 24'h000200);
      chk8(view.cpu_flag_word & 8'h84, 8'h04);
      do_op(OP_DIR_WR, SFR_ACC, 8'h64, 16'h0000);
      do_op(OP_DIR_WR, SFR_B, 8'h07, 16'h0000);
      do_op(OP_DIV, 8'h00, 8'h00, 16'h0000);
      chkw({view.b, view.acc}, 24'h00020E);
      $display("test muldiv done");

      do_op(OP_DIR_WR, SFR_DPL, 8'hFF, 16'h0000);
      do_op(OP_DIR_WR, SFR_DPH, 8'h12, 16'h0000);
      chkw(view.external_data_pointer, 24'h0012FF);
      do_op(OP_EXTERNAL_DATA_POINTER_INC, 8'h00, 8'h00, 16'h0000);
      do_op(OP_DIR_WR, SFR_PAGE, 8'h03, 16'h0000);
      chkw(view.extAddr, 24'h031300);
      chkw(view.pc, 24'h000000);
      do_op(OP_EXTERNAL_DATA_POINTER_LOAD, 8'h00, 8'h00, 16'hABCD);
      chkw(view.external_data_pointer, 24'h00ABCD);
      $display("test pointer done");

      do_op(OP_CODE_WR, 8'h00, 8'hA5, 16'h1234);
      chk8({7'h00, cwr}, 8'h00);
      progEnable = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      do_op(OP_CODE_WR, 8'h00, 8'hA5, 16'h1234);
      chk8({7'h00, cwr}, 8'h01);
      chk8(code.data, 8'hA5);
      chkw(code.addr, 24'h001234);
      progEnable = 1'b0;
      $display("test code write done");
      end_sim();
   end
endmodule : crs_core_regs_tb
